// ==== logic/ltc_tuning_regs.sv ====
// Display tuning register bank: Avalon-MM slave, field outputs and write flags
//
// Overview of operation
// - Red pre-discharge code, bits 3-0, reset 0110b
// - Green pre-discharge code, bits 7-4, reset 0110b
// - Blue pre-discharge code, bits 11-8, reset 0110b
// - Dummy one-shot levels, bits 23-12, reset zero
// - One-shot levels, bits 35-24, reset zero
// - Immunity selects bits 39-41, reset one, 0=high
// - Bit 42 enables maximum subperiod of 256
// - Geometry bits 45-43 reset 111b; 16x16, 32x32
// - Code 010b: 48x48, third reversed, order 1-2-3
// - Codes 100b/101b: 48x64, third/fourth reversed
// - Code 111b: 64x64, order 1-4-2-3
// - Bit 47 enables matrix power saving
module ltc_tuning_regs
  import ltc_pkg::*;
#(
  parameter int CFG_W = 48
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Colour tuning fields
  output logic      [3:0]  red_predischarge_volt,
  output logic      [3:0]  green_predischarge_volt,
  output logic      [3:0]  blue_predischarge_volt,
  output logic      [3:0]  red_dummy_oneshot_level,
  output logic      [3:0]  green_dummy_oneshot_level,
  output logic      [3:0]  blue_dummy_oneshot_level,
  output logic      [3:0]  red_oneshot_level,
  output logic      [3:0]  green_oneshot_level,
  output logic      [3:0]  blue_oneshot_level,
  output logic             red_group_immunity_sel,
  output logic             green_group_immunity_sel,
  output logic             blue_group_immunity_sel,
  // Mode controls
  output logic             long_subperiod_enable,
  output logic      [2:0]  module_geometry_sel,
  output logic             matrix_power_save_enable,
  // Decoded scan geometry
  output ltc_geom_t        scan_geom,
  // Review flag: sticky write of a suspicious value
  output logic             cfg_review_flag
);

  // Whole module state
  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    ltc_geom_t        geom;
    logic [2:0]       status;
    logic             ack;
    logic [31:0]      rdata;
  } ltc_state_t;

  ltc_state_t state_q;
  ltc_state_t state_d;
  ltc_geom_t  geom_next;
  logic [CFG_W-1:0] cfg_next;

  // Byte-lane merge of a write into the 48-bit register
  function automatic logic [CFG_W-1:0] ltc_merge(
    input logic [CFG_W-1:0] cur,
    input logic             hi,
    input logic [31:0]      wd,
    input logic [3:0]       be
  );
    logic [CFG_W-1:0] res;
    res = cur;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b] && (!hi || b < 2))
      begin
        if (hi)
          res[32 + 8*b +: 8] = wd[8*b +: 8];
        else
          res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    // Reserved bits are never stored, so they always read zero
    return res & LTC_CFG_WMASK;
  endfunction : ltc_merge

  // Ambiguous pre-discharge code: above 1001b except the top 2.1V code
  function automatic logic ltc_odd_pdc(input logic [3:0] code);
    return (code > LTC_PDC_LAST_CLEAN) && (code != LTC_PDC_TOP);
  endfunction : ltc_odd_pdc

  // Geometry decode of the value about to be stored, so it lands with it
  ltc_geom_decode u_geom (
    .geom_code (cfg_next[LTC_POS_GEOM +: 3]),
    .geom      (geom_next)
  );

  // Next-state: write path, flags, read path
  always_comb
  begin
    logic access;
    logic hi_sel;
    logic cfg_wr;
    logic [31:0] rd;
    access  = (avs_read || avs_write) && !state_q.ack;
    hi_sel  = (avs_address == LTC_ADDR_CFG_HI);
    cfg_wr  = access && avs_write && (hi_sel || avs_address == LTC_ADDR_CFG_LO);
    rd      = '0;
    state_d = state_q;
    cfg_next = state_q.cfg;
    if (cfg_wr)
      cfg_next = ltc_merge(state_q.cfg, hi_sel, avs_writedata, avs_byteenable);
    state_d.cfg  = cfg_next;
    state_d.geom = geom_next;
    state_d.ack  = access;
    // Software clear first, so a same-cycle set below wins
    if (access && avs_write && avs_address == LTC_ADDR_FLAG_CLR)
      state_d.status = state_q.status & ~avs_writedata[2:0];
    // Only lanes actually written flag, so an old code is not reported again
    if (cfg_wr && !hi_sel)
    begin
      if ((avs_byteenable[0] && ltc_odd_pdc(cfg_next[LTC_POS_PDC_R +: 4]))
          || (avs_byteenable[0] && ltc_odd_pdc(cfg_next[LTC_POS_PDC_G +: 4]))
          || (avs_byteenable[1] && ltc_odd_pdc(cfg_next[LTC_POS_PDC_B +: 4])))
        state_d.status[LTC_ST_ODD_PDC] = 1'b1;
    end
    if (cfg_wr && hi_sel)
    begin
      if (avs_byteenable[1] && (cfg_next[LTC_POS_GEOM +: 3] == LTC_GEOM_48_132
                                || cfg_next[LTC_POS_GEOM +: 3] == LTC_GEOM_64_1234))
        state_d.status[LTC_ST_ODD_GEOM] = 1'b1;
      if ((avs_byteenable[0] && avs_writedata[6:4] != 3'h0) || (avs_byteenable[1] && avs_writedata[14]))
        state_d.status[LTC_ST_RSVD_WR] = 1'b1;
    end
    // Read data registered; unmapped addresses read zero
    case (avs_address)
      LTC_ADDR_CFG_LO:   rd = state_q.cfg[31:0];
      LTC_ADDR_CFG_HI:   rd = {16'h0000, state_q.cfg[CFG_W-1:32]};
      LTC_ADDR_STATUS:   rd = {29'h0, state_q.status};
      default:           rd = '0;
    endcase
    state_d.rdata = (access && avs_read) ? rd : state_q.rdata;
  end

  // State register; constants only under reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q       <= '0;
      state_q.cfg   <= LTC_RST_CFG;
      state_q.geom  <= '{devices_m1: 2'h3, rows_m1: 7'h3f, cols_m1: 7'h3f,
                         third_rev: 1'b1, fourth_rev: 1'b1,
                         scan_order: {LTC_GRP_THREE, LTC_GRP_TWO, LTC_GRP_FOUR, LTC_GRP_ONE}};
    end
    else
      state_q <= state_d;
  end

  // One wait cycle per access: waitrequest drops the cycle after the request
  assign avs_waitrequest = !state_q.ack;
  assign avs_readdata    = state_q.rdata;

  // Field outputs straight from the stored register
  assign red_predischarge_volt     = state_q.cfg[LTC_POS_PDC_R +: 4];
  assign green_predischarge_volt   = state_q.cfg[LTC_POS_PDC_G +: 4];
  assign blue_predischarge_volt    = state_q.cfg[LTC_POS_PDC_B +: 4];
  assign red_dummy_oneshot_level   = state_q.cfg[LTC_POS_DUMMY_R +: 4];
  assign green_dummy_oneshot_level = state_q.cfg[LTC_POS_DUMMY_G +: 4];
  assign blue_dummy_oneshot_level  = state_q.cfg[LTC_POS_DUMMY_B +: 4];
  assign red_oneshot_level         = state_q.cfg[LTC_POS_SHOT_R +: 4];
  assign green_oneshot_level       = state_q.cfg[LTC_POS_SHOT_G +: 4];
  assign blue_oneshot_level        = state_q.cfg[LTC_POS_SHOT_B +: 4];
  assign red_group_immunity_sel    = state_q.cfg[LTC_POS_IMM_R];
  assign green_group_immunity_sel  = state_q.cfg[LTC_POS_IMM_G];
  assign blue_group_immunity_sel   = state_q.cfg[LTC_POS_IMM_B];
  assign long_subperiod_enable     = state_q.cfg[LTC_POS_LONG_SUBP];
  assign module_geometry_sel       = state_q.cfg[LTC_POS_GEOM +: 3];
  assign matrix_power_save_enable  = state_q.cfg[LTC_POS_PWR_SAVE];
  assign scan_geom                 = state_q.geom;
  assign cfg_review_flag           = |state_q.status;

endmodule : ltc_tuning_regs

// ==== logic/ltc_pkg.sv ====
// Package: register map, field layout, reset values and encodings of the tuning register
package ltc_pkg;

  // Avalon word addresses (byte offset / 4), 48-bit register split in two words
  localparam logic [3:0]  LTC_ADDR_CFG_LO    = 4'h0;
  localparam logic [3:0]  LTC_ADDR_CFG_HI    = 4'h1;
  localparam logic [3:0]  LTC_ADDR_STATUS    = 4'h2;
  localparam logic [3:0]  LTC_ADDR_FLAG_CLR  = 4'h3;

  // Field positions (low bit) within the 48-bit register
  localparam int          LTC_POS_PDC_R      = 0;
  localparam int          LTC_POS_PDC_G      = 4;
  localparam int          LTC_POS_PDC_B      = 8;
  localparam int          LTC_POS_DUMMY_R    = 12;
  localparam int          LTC_POS_DUMMY_G    = 16;
  localparam int          LTC_POS_DUMMY_B    = 20;
  localparam int          LTC_POS_SHOT_R     = 24;
  localparam int          LTC_POS_SHOT_G     = 28;
  localparam int          LTC_POS_SHOT_B     = 32;
  localparam int          LTC_POS_RSVD_LO    = 36;
  localparam int          LTC_POS_IMM_R      = 39;
  localparam int          LTC_POS_IMM_G      = 40;
  localparam int          LTC_POS_IMM_B      = 41;
  localparam int          LTC_POS_LONG_SUBP  = 42;
  localparam int          LTC_POS_GEOM       = 43;
  localparam int          LTC_POS_RSVD_HI    = 46;
  localparam int          LTC_POS_PWR_SAVE   = 47;

  // Reset values
  localparam logic [3:0]  LTC_RST_PDC        = 4'h6;
  localparam logic [3:0]  LTC_RST_LEVEL      = 4'h0;
  localparam logic        LTC_RST_IMM        = 1'b1;
  localparam logic        LTC_RST_LONG_SUBP  = 1'b0;
  localparam logic [2:0]  LTC_RST_GEOM       = 3'h7;
  localparam logic        LTC_RST_PWR_SAVE   = 1'b0;
  localparam logic [47:0] LTC_RST_CFG        = 48'h3b8000000666;

  // Writable mask: reserved bits 38-36 and 46 stay zero
  localparam logic [47:0] LTC_CFG_WMASK      = 48'hbf8fffffffff;

  // Pre-discharge codes with a clean, unique voltage mapping end here
  localparam logic [3:0]  LTC_PDC_LAST_CLEAN = 4'h9;
  localparam logic [3:0]  LTC_PDC_TOP        = 4'hf;

  // Status word bit positions
  localparam int          LTC_ST_ODD_PDC     = 0;
  localparam int          LTC_ST_ODD_GEOM    = 1;
  localparam int          LTC_ST_RSVD_WR     = 2;

  // Module geometry codes
  localparam logic [2:0]  LTC_GEOM_16        = 3'h0;
  localparam logic [2:0]  LTC_GEOM_32        = 3'h1;
  localparam logic [2:0]  LTC_GEOM_48_123    = 3'h2;
  localparam logic [2:0]  LTC_GEOM_48_132    = 3'h3;
  localparam logic [2:0]  LTC_GEOM_4864_123  = 3'h4;
  localparam logic [2:0]  LTC_GEOM_4864_132  = 3'h5;
  localparam logic [2:0]  LTC_GEOM_64_1234   = 3'h6;
  localparam logic [2:0]  LTC_GEOM_64_1423   = 3'h7;

  // Scan group indices (one-based as printed, stored zero-based)
  localparam logic [1:0]  LTC_GRP_ONE        = 2'h0;
  localparam logic [1:0]  LTC_GRP_TWO        = 2'h1;
  localparam logic [1:0]  LTC_GRP_THREE      = 2'h2;
  localparam logic [1:0]  LTC_GRP_FOUR       = 2'h3;

  // Scan geometry decode result
  typedef struct packed {
    logic [1:0] devices_m1;    // Stacked devices minus one
    logic [6:0] rows_m1;       // Pixel rows minus one
    logic [6:0] cols_m1;       // Pixel columns minus one
    logic       third_rev;     // Third stacked device reversed
    logic       fourth_rev;    // Fourth stacked device reversed
    logic [7:0] scan_order;    // Four 2-bit group slots, slot 0 in low bits
  } ltc_geom_t;

endpackage : ltc_pkg

// ==== logic/ltc_geom_decode.sv ====
// Module geometry decoder: size code to rows, columns, reversal and scan order
module ltc_geom_decode
  import ltc_pkg::*;
(
  // Code in
  input  wire logic [2:0] geom_code,
  // Decoded geometry
  output ltc_geom_t       geom
);

  // Pure lookup; registered by the caller so outputs stay flop-driven
  always_comb
  begin
    geom            = '0;
    geom.scan_order = {LTC_GRP_FOUR, LTC_GRP_THREE, LTC_GRP_TWO, LTC_GRP_ONE};
    case (geom_code)
      LTC_GEOM_16:
      begin
        geom.devices_m1 = 2'h0;
        geom.rows_m1    = 7'h0f;
        geom.cols_m1    = 7'h0f;
      end
      LTC_GEOM_32:
      begin
        geom.devices_m1 = 2'h1;
        geom.rows_m1    = 7'h1f;
        geom.cols_m1    = 7'h1f;
      end
      LTC_GEOM_48_123:
      begin
        geom.devices_m1 = 2'h2;
        geom.rows_m1    = 7'h2f;
        geom.cols_m1    = 7'h2f;
        geom.third_rev  = 1'b1;
        geom.scan_order = {LTC_GRP_FOUR, LTC_GRP_THREE, LTC_GRP_TWO, LTC_GRP_ONE};
      end
      LTC_GEOM_48_132:
      begin
        geom.devices_m1 = 2'h2;
        geom.rows_m1    = 7'h2f;
        geom.cols_m1    = 7'h2f;
        geom.third_rev  = 1'b1;
        geom.scan_order = {LTC_GRP_FOUR, LTC_GRP_TWO, LTC_GRP_THREE, LTC_GRP_ONE};
      end
      LTC_GEOM_4864_123:
      begin
        geom.devices_m1 = 2'h3;
        geom.rows_m1    = 7'h3f;
        geom.cols_m1    = 7'h2f;
        geom.third_rev  = 1'b1;
        geom.fourth_rev = 1'b1;
        geom.scan_order = {LTC_GRP_FOUR, LTC_GRP_THREE, LTC_GRP_TWO, LTC_GRP_ONE};
      end
      LTC_GEOM_4864_132:
      begin
        geom.devices_m1 = 2'h3;
        geom.rows_m1    = 7'h3f;
        geom.cols_m1    = 7'h2f;
        geom.third_rev  = 1'b1;
        geom.fourth_rev = 1'b1;
        geom.scan_order = {LTC_GRP_FOUR, LTC_GRP_TWO, LTC_GRP_THREE, LTC_GRP_ONE};
      end
      LTC_GEOM_64_1234:
      begin
        // Order printed two ways; the plain ascending one is taken
        geom.devices_m1 = 2'h3;
        geom.rows_m1    = 7'h3f;
        geom.cols_m1    = 7'h3f;
        geom.third_rev  = 1'b1;
        geom.fourth_rev = 1'b1;
        geom.scan_order = {LTC_GRP_FOUR, LTC_GRP_THREE, LTC_GRP_TWO, LTC_GRP_ONE};
      end
      LTC_GEOM_64_1423:
      begin
        geom.devices_m1 = 2'h3;
        geom.rows_m1    = 7'h3f;
        geom.cols_m1    = 7'h3f;
        geom.third_rev  = 1'b1;
        geom.fourth_rev = 1'b1;
        geom.scan_order = {LTC_GRP_THREE, LTC_GRP_TWO, LTC_GRP_FOUR, LTC_GRP_ONE};
      end
      default:
      begin
        geom.devices_m1 = 2'h3;
        geom.rows_m1    = 7'h3f;
        geom.cols_m1    = 7'h3f;
      end
    endcase
  end

endmodule : ltc_geom_decode

// ==== testbench/ltc_regs_properties.sv ====
// Checker: bus handshake and field mapping properties of the tuning register bank
module ltc_regs_props
  import ltc_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Avalon-MM slave
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Watched fields
  input wire logic [3:0]  red_predischarge_volt,
  input wire logic [3:0]  green_predischarge_volt,
  input wire logic [3:0]  blue_predischarge_volt,
  input wire logic [3:0]  blue_oneshot_level,
  input wire logic        red_group_immunity_sel,
  input wire logic [2:0]  module_geometry_sel,
  input wire logic        matrix_power_save_enable,
  input wire ltc_geom_t   scan_geom
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Acknowledged writes; fields must already show the data then
  wire ack_lo = !avs_waitrequest && avs_write && avs_address == LTC_ADDR_CFG_LO;
  wire ack_hi = !avs_waitrequest && avs_write && avs_address == LTC_ADDR_CFG_HI;
  sequence req_s; $rose(avs_read || avs_write); endsequence
  sequence ack_s; !avs_waitrequest ##1 avs_waitrequest; endsequence

  answer_one_cycle_a: assert property (req_s |=> ack_s)
    else $error("waitrequest not low for exactly one cycle");
  ack_needs_req_a: assert property (!avs_waitrequest |-> (avs_read || avs_write))
    else $error("acknowledge without request");
  lo_lane_zero_a: assert property (ack_lo && avs_byteenable[0] |->
    {green_predischarge_volt, red_predischarge_volt} == avs_writedata[7:0])
    else $error("low lane 0 fields differ from write data");
  lo_lane_one_a: assert property (ack_lo && avs_byteenable[1] |->
    blue_predischarge_volt == avs_writedata[11:8])
    else $error("blue pre-discharge differs from write data");
  hi_lane_zero_a: assert property (ack_hi && avs_byteenable[0] |->
    {red_group_immunity_sel, blue_oneshot_level} == {avs_writedata[7], avs_writedata[3:0]})
    else $error("high lane 0 fields differ from write data");
  hi_lane_one_a: assert property (ack_hi && avs_byteenable[1] |->
    {matrix_power_save_enable, module_geometry_sel} == {avs_writedata[15], avs_writedata[13:11]})
    else $error("high lane 1 fields differ from write data");
  reserved_reads_a: assert property (!avs_waitrequest && avs_read && avs_address == LTC_ADDR_CFG_HI |->
    avs_readdata[31:16] == 16'h0 && avs_readdata[14] == 1'b0 && avs_readdata[6:4] == 3'h0)
    else $error("reserved bits read nonzero");
  geom_only_write_a: assert property ($changed(module_geometry_sel) |-> ack_hi)
    else $error("geometry changed without write");
  order_reset_code_a: assert property (module_geometry_sel == 3'h7 |->
    scan_geom.scan_order == 8'h9c && scan_geom.third_rev && scan_geom.fourth_rev)
    else $error("wrong decode of code 111b");
  order_three_a: assert property (module_geometry_sel == 3'h2 |->
    scan_geom.scan_order[5:0] == 6'h24 && scan_geom.third_rev && !scan_geom.fourth_rev)
    else $error("wrong decode of code 010b");
endmodule : ltc_regs_props

bind ltc_tuning_regs ltc_regs_props i_props (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .red_predischarge_volt(red_predischarge_volt),
  .green_predischarge_volt(green_predischarge_volt), .blue_predischarge_volt(blue_predischarge_volt),
  .blue_oneshot_level(blue_oneshot_level), .red_group_immunity_sel(red_group_immunity_sel),
  .module_geometry_sel(module_geometry_sel), .matrix_power_save_enable(matrix_power_save_enable),
  .scan_geom(scan_geom));

// ==== testbench/testbench.sv ====
// Testbench: register bank driven over Avalon-MM, fields checked against a bench model
module testbench
  import ltc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] RST_EXP = 48'h3b8000000666;
  localparam logic [47:0] RW_MASK = 48'hbf8fffffffff;
  // Expected {third_rev, fourth_rev, scan slots} and {devices-1, rows-1, cols-1} per geometry code
  localparam logic [9:0] GEO [8] = '{10'h000, 10'h000, 10'h224, 10'h218, 10'h3e4, 10'h3d8, 10'h3e4, 10'h39c};
  localparam logic [15:0] DIM [8] = '{16'h078f, 16'h4f9f, 16'h97af, 16'h97af, 16'hdfaf, 16'hdfaf, 16'hdfbf, 16'hdfbf};
  logic sys_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, cfg_review_flag, long_subperiod_enable, matrix_power_save_enable;
  logic [3:0] red_predischarge_volt, green_predischarge_volt, blue_predischarge_volt;
  logic [3:0] red_dummy_oneshot_level, green_dummy_oneshot_level, blue_dummy_oneshot_level;
  logic [3:0] red_oneshot_level, green_oneshot_level, blue_oneshot_level;
  logic red_group_immunity_sel, green_group_immunity_sel, blue_group_immunity_sel;
  logic [2:0] module_geometry_sel;
  ltc_geom_t scan_geom;
  logic [47:0] exp_cfg, fld;
  logic [25:0] msk;
  int err_total = 0, n_checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  // Field outputs packed back into register layout, reserved places as zero
  assign fld = {matrix_power_save_enable, 1'b0, module_geometry_sel, long_subperiod_enable, blue_group_immunity_sel,
    green_group_immunity_sel, red_group_immunity_sel, 3'h0, blue_oneshot_level, green_oneshot_level,
    red_oneshot_level, blue_dummy_oneshot_level, green_dummy_oneshot_level, red_dummy_oneshot_level,
    blue_predischarge_volt, green_predischarge_volt, red_predischarge_volt};

  ltc_tuning_regs i_dut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .red_predischarge_volt(red_predischarge_volt),
    .green_predischarge_volt(green_predischarge_volt), .blue_predischarge_volt(blue_predischarge_volt),
    .red_dummy_oneshot_level(red_dummy_oneshot_level), .green_dummy_oneshot_level(green_dummy_oneshot_level),
    .blue_dummy_oneshot_level(blue_dummy_oneshot_level), .red_oneshot_level(red_oneshot_level),
    .green_oneshot_level(green_oneshot_level), .blue_oneshot_level(blue_oneshot_level),
    .red_group_immunity_sel(red_group_immunity_sel), .green_group_immunity_sel(green_group_immunity_sel),
    .blue_group_immunity_sel(blue_group_immunity_sel), .long_subperiod_enable(long_subperiod_enable),
    .module_geometry_sel(module_geometry_sel), .matrix_power_save_enable(matrix_power_save_enable),
    .scan_geom(scan_geom), .cfg_review_flag(cfg_review_flag));

  task chk_read(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_read

  task chk_field(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_field

  // One bus transfer; waitrequest and read data taken at the same rising edge
  task xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 40)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 40) chk_read("waitrequest", 32'h0, 32'h1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Idle edge, so the next call never re-raises in this time step
    @(posedge sys_clk);
  endtask : xfer

  // Write one word of the register and update the bench model by lane
  task wr_cfg(input logic hi, input logic [31:0] d, input logic [3:0] be);
    logic [47:0] m;
    logic [47:0] v;
    m = '0;
    v = hi ? {d[15:0], 32'h0} : {16'h0, d};
    for (int i = 0; i < 4; i++)
      if (be[i] && !(hi && i > 1)) m[(hi ? 32 : 0) + 8 * i +: 8] = 8'hff;
    m = m & RW_MASK;
    exp_cfg = (exp_cfg & ~m) | (v & m);
    xfer(1'b1, {3'h0, hi}, d, be);
  endtask : wr_cfg

  task rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk_read(nm, e, rd);
  endtask : rd_chk

  task complete_run;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #50us;
    err_total++;
    complete_run();
  end

  initial
  begin
    exp_cfg = RST_EXP;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk_field("reset fields", RST_EXP, fld);
    rd_chk(4'h0, 32'h00000666, "cfg low");
    rd_chk(4'h1, 32'h00003b80, "cfg high");
    rd_chk(4'h2, 32'h0, "status reset");
    $display("Test reset values done");
    // All ones: reserved places must stay zero and raise the review flag
    wr_cfg(1'b0, 32'hffffffff, 4'hf); // top code assumes ample colour supplies
    wr_cfg(1'b1, 32'hffffffff, 4'hf);
    chk_field("ones fields", exp_cfg, fld);
    rd_chk(4'h1, 32'h0000bf8f, "cfg high ones");
    rd_chk(4'h2, 32'h4, "status reserved");
    chk_read("review flag", 32'h1, {31'h0, cfg_review_flag});
    xfer(1'b1, 4'h3, 32'h7, 4'hf);
    chk_read("review flag clear", 32'h0, {31'h0, cfg_review_flag});
    $display("Test reserved bits done");
    // Single lanes in turn; green code 1010b is an ambiguous one
    for (int b = 0; b < 4; b++)
    begin
      wr_cfg(1'b0, 32'h9c3b7ea1, 4'h1 << b);
      chk_field("lane fields", exp_cfg, fld);
    end
    rd_chk(4'h2, 32'h1, "status pdc");
    xfer(1'b1, 4'h3, 32'h7, 4'hf);
    $display("Test byte lanes done");
    // Every geometry code; slots unchecked for small sizes, last slot only for four devices
    for (int g = 0; g < 8; g++)
    begin
      wr_cfg(1'b1, {18'h0, 3'(g), 11'h0}, 4'h2);
      chk_field("geom fields", exp_cfg, fld);
      msk = {(g < 2) ? 10'h300 : ((g < 4) ? 10'h33f : 10'h3ff), 16'hffff};
      chk_field("geom decode", 48'({GEO[g], DIM[g]} & msk),
        48'({scan_geom.third_rev, scan_geom.fourth_rev, scan_geom.scan_order, scan_geom.devices_m1,
        scan_geom.rows_m1, scan_geom.cols_m1} & msk));
    end
    rd_chk(4'h2, 32'h2, "status geom");
    $display("Test geometry done");
    // Unmapped address: write ignored, read zero
    xfer(1'b1, 4'h9, 32'hffffffff, 4'hf);
    chk_field("unmapped write", exp_cfg, fld);
    rd_chk(4'h9, 32'h0, "unmapped read");
    $display("Test unmapped done");
    complete_run();
  end
endmodule : testbench
